//--- rtl/flash_host_pkg.sv
package flash_host_pkg;

    // bus and counter widths
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 4;
    localparam int PWR_W  = 5;
    localparam int STEP_W = 3;

    // sector field of the address
    localparam int SECTOR_HI = 19;
    localparam int SECTOR_LO = 12;

    // clock, strobe and power-up timing
    localparam int CLK_PERIOD_NS     = 100;
    localparam int STROBE_LOW_MIN_NS = 5;
    localparam int STROBE_LOW_RAW    =
        (STROBE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] STROBE_LOW_CYC =
        CNT_W'((STROBE_LOW_RAW < 1) ? 1 : STROBE_LOW_RAW);
    localparam logic [CNT_W-1:0] READ_LOW_CYC     = 4'h2;
    localparam logic [PWR_W-1:0] POWERUP_WAIT_CYC = 5'h10;

    // unlock and command addresses
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR_WORD = 20'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR_WORD = 20'h002aa;
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR_BYTE = 20'h00aaa;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR_BYTE = 20'h00555;
    localparam logic [ADDR_W-1:0] QUERY_ADDR_WORD   = 20'h00055;
    localparam logic [ADDR_W-1:0] QUERY_ADDR_BYTE   = 20'h000aa;
    localparam logic [ADDR_W-1:0] ANY_ADDR          = 20'h00000;

    // sector offsets
    localparam logic [SECTOR_LO-1:0] SECTOR_BASE_OFS = 12'h000;
    localparam logic [SECTOR_LO-1:0] PROT_OFS_WORD   = 12'h002;
    localparam logic [SECTOR_LO-1:0] PROT_OFS_BYTE   = 12'h004;

    // data codes
    localparam logic [DATA_W-1:0] CODE_UNLOCK1    = 16'h00aa;
    localparam logic [DATA_W-1:0] CODE_UNLOCK2    = 16'h0055;
    localparam logic [DATA_W-1:0] CODE_RESET      = 16'h00f0;
    localparam logic [DATA_W-1:0] CODE_SUSPEND    = 16'h00b0;
    localparam logic [DATA_W-1:0] CODE_RESUME     = 16'h0030;
    localparam logic [DATA_W-1:0] CODE_PROGRAM    = 16'h00a0;
    localparam logic [DATA_W-1:0] CODE_ERASE_SET  = 16'h0080;
    localparam logic [DATA_W-1:0] CODE_CHIP_ERASE = 16'h0010;
    localparam logic [DATA_W-1:0] CODE_SECT_ERASE = 16'h0030;
    localparam logic [DATA_W-1:0] CODE_ID_ENTER   = 16'h0090;
    localparam logic [DATA_W-1:0] CODE_QUERY      = 16'h0098;

    // last step index of each sequence
    localparam logic [STEP_W-1:0] LAST_STEP_SINGLE  = 3'h0;
    localparam logic [STEP_W-1:0] LAST_STEP_ID      = 3'h2;
    localparam logic [STEP_W-1:0] LAST_STEP_PROGRAM = 3'h3;
    localparam logic [STEP_W-1:0] LAST_STEP_ERASE   = 3'h5;

    typedef enum logic [3:0] {
        OP_READ,
        OP_RESET,
        OP_PROGRAM,
        OP_CHIP_ERASE,
        OP_SECTOR_ERASE,
        OP_SUSPEND,
        OP_RESUME,
        OP_ID_ENTER,
        OP_ID_READ,
        OP_PROTECT_READ,
        OP_QUERY_ENTER
    } op_e;

endpackage

//--- rtl/flash_bus_cycle.sv
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle
    import flash_host_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // cycle request
    input  wire logic              i_start,
    input  wire logic              i_abort,
    input  wire logic              i_write,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_data,
    output logic                   o_done,
    output logic      [DATA_W-1:0] o_rdata,
    // flash pins
    output logic                   o_ce_n,
    output logic                   o_we_n,
    output logic                   o_oe_n,
    output logic      [ADDR_W-1:0] o_addr,
    output logic      [DATA_W-1:0] o_dq,
    output logic                   o_dq_oe_n,
    input  wire logic [DATA_W-1:0] i_dq
);

    typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD} cyc_e;

    cyc_e             state_ff;
    cyc_e             nxt_state;
    logic             write_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] last_cnt;
    logic             nxt_write;

    // write_ff only updates on the start edge, so look ahead at i_write
    assign nxt_write = (state_ff == CYC_IDLE) ? i_write : write_ff;

    assign last_cnt = write_ff ? STROBE_LOW_CYC - 4'h1 : READ_LOW_CYC - 4'h1;
    assign o_done   = (state_ff == CYC_HOLD);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CYC_IDLE:   if (i_start) nxt_state = CYC_SETUP;
            CYC_SETUP:  nxt_state = CYC_STROBE;
            CYC_STROBE: if (cnt_ff == last_cnt) nxt_state = CYC_HOLD;
            CYC_HOLD:   nxt_state = CYC_IDLE;
            default:    nxt_state = CYC_IDLE;
        endcase
        if (i_abort) nxt_state = CYC_IDLE;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) state_ff <= CYC_IDLE;
        else        state_ff <= nxt_state;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || state_ff != CYC_STROBE) cnt_ff <= '0;
        else                                  cnt_ff <= cnt_ff + 4'h1;
    end

    // address and data settle a cycle before the strobe falls
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            write_ff <= 1'b0;
            o_addr   <= '0;
            o_dq     <= '0;
        end else if (state_ff == CYC_IDLE && i_start) begin
            write_ff <= i_write;
            o_addr   <= i_addr;
            o_dq     <= i_data;
        end
    end

    // strobes come from flops so no decode glitch reaches the pins
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_ce_n    <= 1'b1;
            o_we_n    <= 1'b1;
            o_oe_n    <= 1'b1;
            o_dq_oe_n <= 1'b1;
        end else begin
            o_ce_n    <= !(nxt_state == CYC_SETUP || nxt_state == CYC_STROBE);
            o_we_n    <= !(nxt_state == CYC_STROBE && write_ff);
            o_oe_n    <= !(nxt_state == CYC_STROBE && !write_ff);
            o_dq_oe_n <= !(nxt_state != CYC_IDLE && nxt_write);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) o_rdata <= '0;
        else if (state_ff == CYC_STROBE && !write_ff && cnt_ff == last_cnt)
            o_rdata <= i_dq;
    end

endmodule // flash_bus_cycle
`default_nettype wire

//--- rtl/flash_cmd_host.sv
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_host
    import flash_host_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // supply monitor
    input  wire logic              i_supply_ok,
    // command port
    input  wire logic              i_req,
    input  wire op_e               i_op,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_byte_mode,
    output logic                   o_ready,
    output logic                   o_done,
    output logic                   o_rvalid,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_id_mode,
    // flash pins
    output logic                   o_ce_n,
    output logic                   o_we_n,
    output logic                   o_oe_n,
    output logic                   o_byte_n,
    output logic      [ADDR_W-1:0] o_addr,
    output logic      [DATA_W-1:0] o_dq,
    output logic                   o_dq_oe_n,
    input  wire logic [DATA_W-1:0] i_dq
);

    typedef enum logic [1:0] {ST_POWER, ST_IDLE, ST_ISSUE, ST_WAIT} main_e;

    main_e             state_ff;
    op_e               op_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic              byte_ff;
    logic [STEP_W-1:0] step_ff;
    logic [PWR_W-1:0]  pwr_cnt_ff;
    logic [ADDR_W-1:0] step_addr;
    logic [DATA_W-1:0] step_data;
    logic              step_write;
    logic [STEP_W-1:0] last_step;
    logic [ADDR_W-1:0] unlock1_addr;
    logic [ADDR_W-1:0] unlock2_addr;
    logic [ADDR_W-1:0] sector_base;
    logic              cyc_done;
    logic              seq_end;
    logic              abort;

    assign abort   = !i_supply_ok;
    assign o_ready = (state_ff == ST_IDLE);
    assign seq_end = (state_ff == ST_WAIT) && cyc_done && (step_ff == last_step);
    assign o_byte_n = !byte_ff;

    // unlock and command addresses follow the bus width
    assign unlock1_addr = byte_ff ? UNLOCK1_ADDR_BYTE : UNLOCK1_ADDR_WORD;
    assign unlock2_addr = byte_ff ? UNLOCK2_ADDR_BYTE : UNLOCK2_ADDR_WORD;
    assign sector_base  = {addr_ff[SECTOR_HI:SECTOR_LO], SECTOR_BASE_OFS};

    always_comb begin
        step_addr  = ANY_ADDR;
        step_data  = CODE_RESET;
        step_write = 1'b1;
        last_step  = LAST_STEP_SINGLE;
        case (step_ff)
            3'h0, 3'h3: begin
                step_addr = unlock1_addr;
                step_data = CODE_UNLOCK1;
            end
            3'h1, 3'h4: begin
                step_addr = unlock2_addr;
                step_data = CODE_UNLOCK2;
            end
            default: step_addr = unlock1_addr;
        endcase
        case (op_ff)
            OP_PROGRAM: begin
                last_step = LAST_STEP_PROGRAM;
                if (step_ff == 3'h2) step_data = CODE_PROGRAM;
                if (step_ff == 3'h3) begin
                    step_addr = addr_ff;
                    step_data = wdata_ff;
                end
            end
            OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
                last_step = LAST_STEP_ERASE;
                if (step_ff == 3'h2) step_data = CODE_ERASE_SET;
                if (step_ff == 3'h5) begin
                    step_data = (op_ff == OP_CHIP_ERASE) ? CODE_CHIP_ERASE
                                                         : CODE_SECT_ERASE;
                    if (op_ff == OP_SECTOR_ERASE) step_addr = sector_base;
                end
            end
            OP_ID_ENTER: begin
                last_step = LAST_STEP_ID;
                if (step_ff == 3'h2) step_data = CODE_ID_ENTER;
            end
            OP_RESET: begin
                step_addr = ANY_ADDR;
                step_data = CODE_RESET;
            end
            OP_SUSPEND: begin
                step_addr = ANY_ADDR;
                step_data = CODE_SUSPEND;
            end
            OP_RESUME: begin
                step_addr = ANY_ADDR;
                step_data = CODE_RESUME;
            end
            OP_QUERY_ENTER: begin
                step_addr = byte_ff ? QUERY_ADDR_BYTE : QUERY_ADDR_WORD;
                step_data = CODE_QUERY;
            end
            OP_PROTECT_READ: begin
                step_write = 1'b0;
                step_addr  = {addr_ff[SECTOR_HI:SECTOR_LO],
                              byte_ff ? PROT_OFS_BYTE : PROT_OFS_WORD};
            end
            default: begin
                step_write = 1'b0;
                step_addr  = addr_ff;
            end
        endcase
    end

    // supply loss drops any sequence; the device has reset anyway
    always_ff @(posedge i_clk) begin
        if (i_srst) state_ff <= ST_POWER;
        else if (abort) state_ff <= ST_POWER;
        else begin
            case (state_ff)
                ST_POWER: if (pwr_cnt_ff == '0) state_ff <= ST_IDLE;
                ST_IDLE:  if (i_req) state_ff <= ST_ISSUE;
                ST_ISSUE: state_ff <= ST_WAIT;
                ST_WAIT: begin
                    if (seq_end)       state_ff <= ST_IDLE;
                    else if (cyc_done) state_ff <= ST_ISSUE;
                end
                default: state_ff <= ST_POWER;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || abort) pwr_cnt_ff <= POWERUP_WAIT_CYC;
        else if (state_ff == ST_POWER && pwr_cnt_ff != '0)
            pwr_cnt_ff <= pwr_cnt_ff - 5'h01;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            op_ff    <= OP_READ;
            addr_ff  <= '0;
            wdata_ff <= '0;
            byte_ff  <= 1'b0;
        end else if (o_ready && i_req) begin
            op_ff    <= i_op;
            addr_ff  <= i_addr;
            wdata_ff <= i_wdata;
            byte_ff  <= i_byte_mode;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || state_ff == ST_IDLE) step_ff <= '0;
        else if (state_ff == ST_WAIT && cyc_done && !seq_end)
            step_ff <= step_ff + 3'h1;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_done   <= 1'b0;
            o_rvalid <= 1'b0;
        end else begin
            o_done   <= seq_end && !abort;
            o_rvalid <= seq_end && !abort && !step_write;
        end
    end

    // identification and query modes stay until a reset command lands or the supply drops
    always_ff @(posedge i_clk) begin
        if (i_srst || abort) o_id_mode <= 1'b0;
        else if (seq_end && op_ff == OP_RESET) o_id_mode <= 1'b0;
        else if (seq_end && (op_ff == OP_ID_ENTER || op_ff == OP_QUERY_ENTER))
            o_id_mode <= 1'b1;
    end

    flash_bus_cycle u_cycle (
        .i_clk     (i_clk),
        .i_srst    (i_srst),
        .i_start   (state_ff == ST_ISSUE),
        .i_abort   (abort),
        .i_write   (step_write),
        .i_addr    (step_addr),
        .i_data    (step_data),
        .o_done    (cyc_done),
        .o_rdata   (o_rdata),
        .o_ce_n    (o_ce_n),
        .o_we_n    (o_we_n),
        .o_oe_n    (o_oe_n),
        .o_addr    (o_addr),
        .o_dq      (o_dq),
        .o_dq_oe_n (o_dq_oe_n),
        .i_dq      (i_dq)
    );

    // helper: write strobes seen in the current sequence
    logic             we_q_ff;
    logic [STEP_W:0]  we_cnt_ff;
    always_ff @(posedge i_clk) begin
        if (i_srst) we_q_ff <= 1'b1;
        else        we_q_ff <= o_we_n;
    end
    always_ff @(posedge i_clk) begin
        if (i_srst || (o_ready && i_req)) we_cnt_ff <= '0;
        else if (we_q_ff && !o_we_n)       we_cnt_ff <= we_cnt_ff + 4'h1;
    end

    AST_LOCKOUT_QUIET: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_supply_ok |=> ##1 (o_we_n && o_ce_n && o_oe_n))
        else $error("strobes active after supply loss");
    AST_NO_ALL_LOW: assert property (@(posedge i_clk) disable iff (i_srst)
        !(!o_ce_n && !o_we_n && !o_oe_n))
        else $error("chip, write and output enable all low");
    AST_WRITE_LEVELS: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_we_n |-> (!o_ce_n && o_oe_n && !o_dq_oe_n))
        else $error("write strobe without proper enables");
    AST_PULSE_WIDTH: assert property (@(posedge i_clk) disable iff (i_srst)
        $fell(o_we_n) |-> !o_we_n [*1] ##1 o_we_n ##1 o_ce_n)
        else $error("write pulse shape wrong");
    AST_ADDR_STABLE: assert property (@(posedge i_clk) disable iff (i_srst)
        (!o_we_n || $rose(o_we_n)) |-> ($stable(o_addr) && $stable(o_dq)))
        else $error("address or data moved around write strobe");
    AST_POWER_WAIT: assert property (@(posedge i_clk) disable iff (i_srst)
        (state_ff == ST_POWER) |-> (o_we_n && !o_ready))
        else $error("write during power-up wait");
    AST_FIRST_UNLOCK: assert property (@(posedge i_clk) disable iff (i_srst)
        ($fell(o_we_n) && we_cnt_ff == '0 && op_ff == OP_PROGRAM)
        |-> (o_dq == CODE_UNLOCK1 &&
             o_addr == (byte_ff ? UNLOCK1_ADDR_BYTE : UNLOCK1_ADDR_WORD)))
        else $error("sequence did not open with unlock");
    AST_PROGRAM_FOUR: assert property (@(posedge i_clk) disable iff (i_srst)
        (seq_end && op_ff == OP_PROGRAM) |=> (we_cnt_ff == 4'h4))
        else $error("program sequence not four writes");
    AST_ERASE_SIX: assert property (@(posedge i_clk) disable iff (i_srst)
        (seq_end && (op_ff == OP_CHIP_ERASE || op_ff == OP_SECTOR_ERASE))
        |=> (we_cnt_ff == 4'h6))
        else $error("erase sequence not six writes");
    AST_SECTOR_ONLY: assert property (@(posedge i_clk) disable iff (i_srst)
        ($fell(o_we_n) && op_ff == OP_SECTOR_ERASE && o_dq == CODE_SECT_ERASE)
        |-> (o_addr[SECTOR_LO-1:0] == SECTOR_BASE_OFS))
        else $error("sector erase address has low bits set");
    AST_RESET_SINGLE: assert property (@(posedge i_clk) disable iff (i_srst)
        (seq_end && op_ff == OP_RESET) |=> (we_cnt_ff == 4'h1 && !o_id_mode))
        else $error("reset command not a single write");

    COV_PROGRAM: cover property (@(posedge i_clk) disable iff (i_srst)
        seq_end && op_ff == OP_PROGRAM);
    COV_SECTOR_ERASE: cover property (@(posedge i_clk) disable iff (i_srst)
        seq_end && op_ff == OP_SECTOR_ERASE && byte_ff);
    COV_ID_READ: cover property (@(posedge i_clk) disable iff (i_srst)
        o_id_mode && o_rvalid);
    COV_ABORT: cover property (@(posedge i_clk) disable iff (i_srst)
        state_ff == ST_WAIT && !i_supply_ok);

endmodule // flash_cmd_host
`default_nettype wire

//--- rtl/README_unused.sv
`timescale 1ns/10ps

//--- verif/flash_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter logic [15:0] MAN_CODE  = 16'h00a1, // arbitrary value
    parameter logic [15:0] DEV_CODE  = 16'h0b2c, // arbitrary value
    parameter logic [7:0]  PROT_SECT = 8'h12,
    parameter int          BUSY_NS   = 2000
) (
    // flash pins
    input  wire logic              i_ce_n,
    input  wire logic              i_we_n,
    input  wire logic              i_oe_n,
    input  wire logic              i_byte_n,
    input  wire logic              i_dq_oe_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_bus,
    output logic      [DATA_W-1:0] o_dq,
    // supply and observation
    input  wire logic              i_supply_ok,
    output var int                 o_n_cmd,
    output var int                 o_bad,
    output logic                   o_id,
    output logic      [ADDR_W-1:0] o_pa,
    output logic      [DATA_W-1:0] o_pd
);
    int                step    = 0;
    logic              in_wr   = 1'b0;
    logic [ADDR_W-1:0] wa      = '0;
    realtime           t_fall  = 0;
    realtime           busy_to = 0;

    initial begin
        o_n_cmd = 0;
        o_bad = 0;
        o_id = 1'b0;
        o_pa = '0;
        o_pd = '0;
    end

    function automatic logic [15:0] rd(input logic [19:0] a,
                                       input logic id, input logic bn);
        if (!id) return a[15:0] ^ 16'hc3a5;
        if (a[11:0] == 12'h0) return MAN_CODE;
        if (a[11:0] == (bn ? 12'h1 : 12'h2)) return DEV_CODE;
        if (a[11:0] == (bn ? 12'h2 : 12'h4))
            return {15'h0, a[19:12] == PROT_SECT};
        return 16'h0;
    endfunction

    // released bus shows the inverse so a stale value never passes
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd(i_addr, o_id, i_byte_n)
                                       : ~rd(i_addr, o_id, i_byte_n);

    always @(negedge i_we_n or negedge i_oe_n or negedge i_dq_oe_n) begin
        if (!i_oe_n && (!i_we_n || !i_dq_oe_n)) o_bad++;
    end

    always @(negedge i_ce_n or negedge i_we_n) begin
        if (!i_ce_n && !i_we_n && i_oe_n) begin
            in_wr = 1'b1;
            wa = i_addr;
            t_fall = $realtime;
        end
    end

    always @(posedge i_ce_n or posedge i_we_n) begin
        if (in_wr) begin
            in_wr = 1'b0;
            if ($realtime - t_fall >= 5.0 && i_supply_ok)
                cmd(wa, i_bus);
        end
    end

    always @(negedge i_supply_ok) begin
        step = 0;
        o_id = 1'b0;
        busy_to = 0;
    end

    task automatic cmd(input logic [19:0] a, input logic [15:0] d);
        logic [19:0] u1;
        logic [19:0] u2;
        logic [19:0] q;
        logic [7:0]  c;
        u1 = i_byte_n ? UNLOCK1_ADDR_WORD : UNLOCK1_ADDR_BYTE;
        u2 = i_byte_n ? UNLOCK2_ADDR_WORD : UNLOCK2_ADDR_BYTE;
        q = i_byte_n ? QUERY_ADDR_WORD : QUERY_ADDR_BYTE;
        c = d[7:0];
        if ($realtime < busy_to) return;
        case (step)
            0: begin
                if (c == 8'hf0 || c == 8'hb0 || c == 8'h30) o_n_cmd++;
                if (c == 8'hf0) o_id = 1'b0;
                if (c == 8'h98 && a == q) begin
                    o_id = 1'b1;
                    o_n_cmd++;
                end
                if (c == 8'haa && a == u1) step = 1;
            end
            1, 5: step = (c == 8'h55 && a == u2) ? step + 1 : 0;
            2: begin
                step = 0;
                if (a == u1 && c == 8'h90) begin
                    o_id = 1'b1;
                    o_n_cmd++;
                end
                if (a == u1 && c == 8'ha0) step = 3;
                if (a == u1 && c == 8'h80) step = 4;
            end
            3: begin
                o_pa = a;
                o_pd = d;
                o_n_cmd++;
                step = 0;
            end
            4: step = (c == 8'haa && a == u1) ? 5 : 0;
            default: begin
                if ((c == 8'h10 && a == u1) || c == 8'h30) begin
                    o_pa = a;
                    o_n_cmd++;
                    busy_to = $realtime + BUSY_NS;
                end
                step = 0;
            end
        endcase
    endtask
endmodule // flash_dev_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import flash_host_pkg::*;
    localparam logic [15:0] MAN  = 16'h00a1; // arbitrary value
    localparam logic [15:0] DEV  = 16'h0b2c; // arbitrary value
    localparam logic [7:0]  PROT = 8'h12;

    logic              clk, srst, supply, req, bm, rv;
    op_e               op;
    logic [ADDR_W-1:0] addr, f_addr, pa;
    logic [DATA_W-1:0] wdata, rdata, f_dq, m_dq, bus, pd;
    logic              ready, done, rvalid, id_mode, ce_n, we_n, oe_n;
    logic              byte_n, dq_oe_n, m_id;
    int                n_cmd, bad;
    int                err_count   = 0;
    int                check_count = 0;
    int                cyc         = 0;

    assign bus = (dq_oe_n === 1'b0) ? f_dq : m_dq;

    flash_cmd_host DUT (
        .i_clk(clk), .i_srst(srst), .i_supply_ok(supply), .i_req(req),
        .i_op(op), .i_addr(addr), .i_wdata(wdata), .i_byte_mode(bm),
        .o_ready(ready), .o_done(done), .o_rvalid(rvalid), .o_rdata(rdata),
        .o_id_mode(id_mode), .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n),
        .o_byte_n(byte_n), .o_addr(f_addr), .o_dq(f_dq),
        .o_dq_oe_n(dq_oe_n), .i_dq(bus));

    flash_dev_model #(.MAN_CODE(MAN), .DEV_CODE(DEV), .PROT_SECT(PROT)) mdl (
        .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_byte_n(byte_n),
        .i_dq_oe_n(dq_oe_n), .i_addr(f_addr), .i_bus(bus), .o_dq(m_dq),
        .i_supply_ok(supply), .o_n_cmd(n_cmd), .o_bad(bad), .o_id(m_id),
        .o_pa(pa), .o_pd(pd));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // generous ceiling: the whole sequence needs well under 1000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic chk_val(input string n, input logic [19:0] e,
                           input logic [19:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic run(input op_e o, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic b,
                       input int inc);
        int n0;
        int k;
        n0 = n_cmd;
        k = 0;
        while (ready !== 1'b1 && k < 60) begin
            @(negedge clk);
            k++;
        end
        req = 1'b1;
        op = o;
        addr = a;
        wdata = d;
        bm = b;
        @(negedge clk);
        req = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        rv = rvalid;
        chk_bit("done", 1'b1, done);
        chk_val("cmds", 20'(n0 + inc), 20'(n_cmd));
    endtask

    task automatic rd_chk(input op_e o, input logic [ADDR_W-1:0] a,
                          input logic b, input logic [DATA_W-1:0] e);
        run(o, a, 16'h0, b, 0);
        chk_bit("rvalid", 1'b1, rv);
        chk_val("read data", {4'h0, e}, {4'h0, rdata});
    endtask

    task automatic t_lock;
        int k;
        for (k = 0; k < POWERUP_WAIT_CYC; k++) begin
            chk_bit("ready in lockout", 1'b0, ready);
            chk_bit("we_n idle", 1'b1, we_n);
            @(negedge clk);
        end
        k = 0;
        while (ready !== 1'b1 && k < 10) begin
            @(negedge clk);
            k++;
        end
        chk_bit("ready after wait", 1'b1, ready);
    endtask

    task automatic t_singles;
        op_e ops[4] = '{OP_RESET, OP_SUSPEND, OP_RESUME, OP_QUERY_ENTER};
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 4; i++)
                run(ops[i], 20'h0, 16'h0, b[0], 1);
            @(negedge clk);
            chk_bit("query id mode", 1'b1, id_mode);
            run(OP_RESET, 20'h0, 16'h0, b[0], 1);
            @(negedge clk);
            chk_bit("reset id mode", 1'b0, id_mode);
        end
    endtask

    task automatic t_program;
        for (int b = 0; b < 2; b++) begin
            run(OP_PROGRAM, 20'h3c5a7, 16'hbe0f, b[0], 1);
            chk_val("program addr", 20'h3c5a7, pa);
            chk_val("program value", 20'h0be0f, {4'h0, pd});
        end
    endtask

    task automatic t_erase;
        run(OP_CHIP_ERASE, 20'h0, 16'h0, 1'b0, 1);
        repeat (25) @(negedge clk);
        run(OP_SECTOR_ERASE, 20'h45abc, 16'h0, 1'b1, 1);
        chk_val("sector", 20'h00045, {12'h0, pa[19:12]});
        repeat (25) @(negedge clk);
    endtask

    task automatic t_ident;
        run(OP_ID_ENTER, 20'h0, 16'h0, 1'b0, 1);
        @(negedge clk);
        chk_bit("id mode", 1'b1, id_mode);
        rd_chk(OP_ID_READ, 20'h00000, 1'b0, MAN);
        rd_chk(OP_ID_READ, 20'h00001, 1'b0, DEV);
        rd_chk(OP_PROTECT_READ, {PROT, 12'h7f3}, 1'b0, 16'h1);
        rd_chk(OP_PROTECT_READ, {PROT, 12'h7f3}, 1'b1, 16'h1);
        rd_chk(OP_PROTECT_READ, 20'h99000, 1'b1, 16'h0);
        run(OP_RESET, 20'h0, 16'h0, 1'b0, 1);
        rd_chk(OP_READ, 20'h01234, 1'b0, 16'h1234 ^ 16'hc3a5);
    endtask

    task automatic t_supply;
        int   n0;
        logic seen;
        n0 = n_cmd;
        seen = 1'b0;
        @(negedge clk);
        req = 1'b1;
        op = OP_PROGRAM;
        @(negedge clk);
        req = 1'b0;
        repeat (6) @(negedge clk);
        supply = 1'b0;
        repeat (30) begin
            @(negedge clk);
            seen |= done;
        end
        supply = 1'b1;
        chk_bit("done after loss", 1'b0, seen);
        chk_val("cmds after loss", 20'(n0), 20'(n_cmd));
        t_lock();
        run(OP_PROGRAM, 20'h0a0a0, 16'h1234, 1'b0, 1);
    endtask

    initial begin
        srst = 1'b1;
        supply = 1'b1;
        req = 1'b0;
        op = OP_READ;
        addr = '0;
        wdata = '0;
        bm = 1'b0;
        rv = 1'b0;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_lock();
        t_singles();
        t_program();
        t_erase();
        t_ident();
        t_supply();
        chk_val("bad strobes", 20'h0, 20'(bad));
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
